// *** rtl/pllfc_core.sv ***
// Purpose: function and initialization word control of the synthesizer
// Assumes: host stops the serial clock while the latch strobe is high
// Notes: the shift word is static when the strobe edge is seen, so a
//        multi-bit capture across domains is safe (held-data handshake)
//
// How it works
// - control bits 10 load function word
// - control bits 11 load and pulse reset
// - counter clear holds counters, three-states pump
// - chip enable low powers down at once
// - arm with sync select 0 powers immediately
// - arm with sync select 1 waits pump event
// - power-down loads counters, pump off, lock reset
// - monitor select bits pick monitor output
// - polarity bit sets phase detector sense
// - tristate bit floats the charge pump
// - fastlock only when enable bit set
// - variant bit chooses host or timer end
// - fastlock off: switch follows variant bit
// - gain boost drives switch low, high current
// - host variant ends on gain boost zero
// - timer variant clears gain boost on timeout
// - four-bit field sets timeout length
// - first divider word after init repeats pulse
// - init pulse also triggers sync power-down if chip enable high
// - 24 bits shifted, strobe rise latches word
`timescale 1ns/100ps
`default_nettype none
`include "pllfc_consts.svh"
module pllfc_core #(
  parameter int WIDTH = `PLLFC_WORD_BITS,
  parameter int TMO_W = 4
) (
  input  wire logic       ref_clk,         // core clock, 125 MHz
  input  wire logic       rst,             // async reset, high
  input  wire logic       link_clk,        // serial clock pin
  input  wire logic       link_data,       // serial data pin
  input  wire logic       latch_strobe,    // latch enable pin
  input  wire logic       chip_enable,     // chip enable pin, low = off
  input  wire logic       pump_event,      // charge pump event, ref_clk pulse
  input  wire logic       compare_tick,    // phase detector cycle pulse
  input  wire logic [7:0] monitor_sources, // internal signals to monitor
  output logic            monitor_output_pin,  // selected monitor signal
  output logic            phase_polarity_out,  // 1 = positive slope
  output logic            pump_tristate,       // charge pump high-z
  output logic            pump_high_current,   // 1 mA selected
  output logic            loop_filter_switch_out, // fastlock switch
  output logic            counter_load,        // hold counters at load
  output logic            counter_reset_pulse, // one-cycle align reset
  output logic            lock_detect_reset,   // clear lock detection
  output logic            powered_down,        // device powered down
  output logic [WIDTH-1:0] ref_word,           // reference divider word
  output logic [WIDTH-1:0] div_word            // main divider word
);
  logic [WIDTH-1:0] shift_word;
  logic [2:0]       strobe_sync;
  logic [2:0]       ce_sync;
  logic             strobe_level;
  logic             ce_level;
  logic [WIDTH-1:0] func_word;
  logic             init_armed;
  logic             gain_boost;
  logic [TMO_W-1:0] tmo_count;
  logic             pd_prog;
  logic [WIDTH-1:0] next_func_word;
  logic [WIDTH-1:0] next_ref_word;
  logic [WIDTH-1:0] next_div_word;
  logic             next_init_armed;
  logic             next_gain_boost;
  logic [TMO_W-1:0] next_tmo_count;
  logic             next_pd_prog;
  logic             next_strobe_level;
  logic             next_ce_level;
  logic             next_reset_pulse;
  logic             strobe_rise;
  logic             pd_now;
  logic             fl_on;
  logic             fl_timer;
  logic             next_monitor;
  logic             next_polarity;
  logic             next_tristate;
  logic             next_high_cur;
  logic             next_switch;
  logic             next_load;
  pllfc_pkg::pllfc_kind_type kind;

  pllfc_serial_rx #(
    .WIDTH (WIDTH)
  ) u_rx (
    .link_clk   (link_clk),
    .rst        (rst),
    .link_data  (link_data),
    .shift_word (shift_word)
  );

  // decode word kind from its two control bits
  function automatic pllfc_pkg::pllfc_kind_type word_kind(
    input logic [WIDTH-1:0] w
  );
    word_kind = pllfc_pkg::pllfc_kind_type'(
      {w[`PLLFC_CTRL_HIGH], w[`PLLFC_CTRL_LOW]});
  endfunction : word_kind

  // pin synchronisers; a change counts when stages two and three agree
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strobe_sync  <= 3'h0;
      ce_sync      <= 3'h0;
      strobe_level <= 1'b0;
      ce_level     <= 1'b0;
    end
    else
    begin
      strobe_sync  <= {strobe_sync[1:0], latch_strobe};
      ce_sync      <= {ce_sync[1:0], chip_enable};
      strobe_level <= next_strobe_level;
      ce_level     <= next_ce_level;
    end
  end

  always_comb
  begin
    next_strobe_level = (strobe_sync[1] == strobe_sync[2]) ?
                        strobe_sync[2] : strobe_level;
    next_ce_level     = (ce_sync[1] == ce_sync[2]) ?
                        ce_sync[2] : ce_level;
  end

  assign strobe_rise = next_strobe_level & ~strobe_level;
  assign kind        = word_kind(shift_word);
  assign fl_on       = func_word[`PLLFC_BIT_FL_ENABLE];
  assign fl_timer    = fl_on & func_word[`PLLFC_BIT_FL_VARIANT];
  // chip enable overrides both programmed bits
  assign pd_now      = ~ce_level | pd_prog;

  // word latching, fastlock timer and power-down sequencing
  always_comb
  begin
    next_func_word    = func_word;
    next_ref_word     = ref_word;
    next_div_word     = div_word;
    next_init_armed   = init_armed;
    next_gain_boost   = gain_boost;
    next_tmo_count    = tmo_count;
    next_pd_prog      = pd_prog;
    next_reset_pulse  = 1'b0;
    // timeout counts comparison cycles while boosted
    if (fl_timer && gain_boost && compare_tick && !pd_now)
    begin
      if (tmo_count == '0)
      begin
        next_gain_boost = 1'b0;
        next_div_word[`PLLFC_BIT_GAIN] = 1'b0;
      end
      else
        next_tmo_count = tmo_count - 1'b1;
    end
    if (pd_now)
      next_tmo_count = func_word[`PLLFC_TMO_MSB:`PLLFC_TMO_LSB];
    if (strobe_rise)
    begin
      case (kind)
        pllfc_pkg::pllfc_func_word:
        begin
          next_func_word = shift_word;
        end
        pllfc_pkg::pllfc_init_word:
        begin
          next_func_word   = shift_word;
          next_reset_pulse = 1'b1;
          next_init_armed  = 1'b1;
        end
        pllfc_pkg::pllfc_ref_word:
        begin
          next_ref_word = shift_word;
        end
        default:
        begin
          next_div_word   = shift_word;
          // host variant leaves fastlock only on a written zero
          next_gain_boost = shift_word[`PLLFC_BIT_GAIN];
          next_tmo_count  = func_word[`PLLFC_TMO_MSB:`PLLFC_TMO_LSB];
          if (init_armed)
          begin
            next_reset_pulse = 1'b1;
            next_init_armed  = 1'b0;
          end
        end
      endcase
    end
    // programmed power-down: async at once, sync on next pump event;
    // init pulse counts as the sync trigger when enabled
    if (!next_func_word[`PLLFC_BIT_PD_ARM])
      next_pd_prog = 1'b0;
    else if (!next_func_word[`PLLFC_BIT_PD_SYNC])
      next_pd_prog = 1'b1;
    else if (pump_event || (next_reset_pulse && ce_level))
      next_pd_prog = 1'b1;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      func_word           <= `PLLFC_FN_RESET;
      ref_word            <= '0;
      div_word            <= '0;
      init_armed          <= 1'b0;
      gain_boost          <= 1'b0;
      tmo_count           <= '0;
      pd_prog             <= 1'b0;
      counter_reset_pulse <= 1'b0;
    end
    else
    begin
      func_word           <= next_func_word;
      ref_word            <= next_ref_word;
      div_word            <= next_div_word;
      init_armed          <= next_init_armed;
      gain_boost          <= next_gain_boost;
      tmo_count           <= next_tmo_count;
      pd_prog             <= next_pd_prog;
      counter_reset_pulse <= next_reset_pulse;
    end
  end

  // analog-facing controls; pulse does not touch reference or buffer
  always_comb
  begin
    next_monitor  = monitor_sources[
      func_word[`PLLFC_MON_MSB:`PLLFC_MON_LSB]];
    next_polarity = func_word[`PLLFC_BIT_POLARITY];
    // clear bit holds counters without causing power-down
    next_load     = pd_now | func_word[`PLLFC_BIT_CLEAR];
    next_tristate = func_word[`PLLFC_BIT_TRISTATE] | next_load
                    | next_reset_pulse;
    next_high_cur = fl_on & gain_boost;
    if (!fl_on)
      next_switch = func_word[`PLLFC_BIT_FL_VARIANT];
    else
      next_switch = ~gain_boost;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      monitor_output_pin     <= 1'b0;
      phase_polarity_out     <= 1'b0;
      pump_tristate          <= 1'b1;
      pump_high_current      <= 1'b0;
      loop_filter_switch_out <= 1'b0;
      counter_load           <= 1'b1;
      lock_detect_reset      <= 1'b1;
      powered_down           <= 1'b1;
    end
    else
    begin
      monitor_output_pin     <= next_monitor;
      phase_polarity_out     <= next_polarity;
      pump_tristate          <= next_tristate;
      pump_high_current      <= next_high_cur;
      loop_filter_switch_out <= next_switch;
      counter_load           <= next_load;
      lock_detect_reset      <= pd_now;
      powered_down           <= pd_now;
    end
  end

  property p_ce_low;
    @(posedge ref_clk) disable iff (rst)
      !ce_level |=> powered_down;
  endproperty
  a_ce_low: assert property (p_ce_low) else $error("ce low not off");

  property p_async_pd;
    @(posedge ref_clk) disable iff (rst)
      func_word[`PLLFC_BIT_PD_ARM] && !func_word[`PLLFC_BIT_PD_SYNC]
      |=> powered_down;
  endproperty
  a_async_pd: assert property (p_async_pd) else $error("async pd late");

  property p_sync_wait;
    @(posedge ref_clk) disable iff (rst)
      ce_level && !pd_prog && !pump_event && !next_reset_pulse
      && next_func_word[`PLLFC_BIT_PD_SYNC] |=> !pd_prog;
  endproperty
  a_sync_wait: assert property (p_sync_wait)
    else $error("sync pd early");

  property p_sync_enter;
    @(posedge ref_clk) disable iff (rst)
      next_func_word[`PLLFC_BIT_PD_ARM] && next_func_word[`PLLFC_BIT_PD_SYNC]
      && pump_event |=> ##1 powered_down;
  endproperty
  a_sync_enter: assert property (p_sync_enter)
    else $error("sync pd missed");

  property p_pd_effects;
    @(posedge ref_clk) disable iff (rst)
      powered_down |-> counter_load && pump_tristate && lock_detect_reset;
  endproperty
  a_pd_effects: assert property (p_pd_effects)
    else $error("pd effects");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      func_word[`PLLFC_BIT_CLEAR] |=> counter_load && pump_tristate;
  endproperty
  a_clear: assert property (p_clear) else $error("clear not held");

  sequence s_init_latch;
    strobe_rise && kind == pllfc_pkg::pllfc_init_word;
  endsequence
  property p_init_pulse;
    @(posedge ref_clk) disable iff (rst)
      s_init_latch |=> counter_reset_pulse ##1 !counter_reset_pulse;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("no pulse");

  property p_div_norepeat;
    @(posedge ref_clk) disable iff (rst)
      strobe_rise && kind == pllfc_pkg::pllfc_div_word && !init_armed
      |=> !counter_reset_pulse;
  endproperty
  a_div_norepeat: assert property (p_div_norepeat)
    else $error("extra pulse");

  property p_switch_off;
    @(posedge ref_clk) disable iff (rst)
      !fl_on ##1 $stable(func_word) |-> loop_filter_switch_out
      == func_word[`PLLFC_BIT_FL_VARIANT];
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch");

  property p_boost;
    @(posedge ref_clk) disable iff (rst)
      fl_on && gain_boost && $stable(func_word)
      |=> pump_high_current && !loop_filter_switch_out;
  endproperty
  a_boost: assert property (p_boost) else $error("boost");
endmodule : pllfc_core
`default_nettype wire

// *** rtl/pllfc_consts.svh ***
// Purpose: bit positions and timing counts of the synthesizer control words
// Assumes: 24-bit words, control bits in the two lowest positions
// Notes: definitions only
`ifndef PLLFC_CONSTS_SVH
`define PLLFC_CONSTS_SVH
`define PLLFC_WORD_BITS      24
`define PLLFC_CTRL_LOW       0
`define PLLFC_CTRL_HIGH      1
`define PLLFC_BIT_CLEAR      2
`define PLLFC_BIT_PD_ARM     3
`define PLLFC_MON_LSB        4
`define PLLFC_MON_MSB        6
`define PLLFC_BIT_POLARITY   7
`define PLLFC_BIT_TRISTATE   8
`define PLLFC_BIT_FL_ENABLE  9
`define PLLFC_BIT_FL_VARIANT 11
`define PLLFC_TMO_LSB        11
`define PLLFC_TMO_MSB        14
`define PLLFC_BIT_PD_SYNC    19
`define PLLFC_BIT_GAIN       21
`define PLLFC_FN_RESET       24'h000000
`define PLLFC_SYNC_STAGES    3
`endif

// *** rtl/pllfc_pkg.sv ***
// Purpose: shared types of the synthesizer control block
// Assumes: nothing beyond the constants header
// Notes: word kinds follow the two control bits
package pllfc_pkg;
  typedef enum logic [1:0]
  {
    pllfc_ref_word  = 2'h0,
    pllfc_div_word  = 2'h1,
    pllfc_func_word = 2'h2,
    pllfc_init_word = 2'h3
  } pllfc_kind_type;
endpackage : pllfc_pkg

// *** rtl/pllfc_serial_rx.sv ***
// Purpose: link-clock shift register of the three-wire programming link
// Assumes: data sampled on rising serial clock edges
// Notes: word held stable after the latch strobe rises, then handed over
`timescale 1ns/100ps
`default_nettype none
`include "pllfc_consts.svh"
module pllfc_serial_rx #(
  parameter int WIDTH = `PLLFC_WORD_BITS
) (
  input  wire logic             link_clk,    // serial clock from host
  input  wire logic             rst,         // async reset, high
  input  wire logic             link_data,   // serial data
  output logic      [WIDTH-1:0] shift_word   // last WIDTH bits shifted
);
  logic [WIDTH-1:0] next_shift_word;

  // shift in msb first; the word is read in the core only after the strobe
  always_comb
  begin
    next_shift_word = {shift_word[WIDTH-2:0], link_data};
  end

  always_ff @(posedge link_clk or posedge rst)
  begin
    if (rst)
      shift_word <= '0;
    else
      shift_word <= next_shift_word;
  end
endmodule : pllfc_serial_rx
`default_nettype wire

// *** bench/pllfc_host_model.sv ***
// Purpose: host end of the three-wire programming link
// Assumes: link clock idles low and stands still between frames
// Notes: the data line shows the inverse of its last bit once released
`timescale 1ns/100ps
`default_nettype none
module pllfc_host_model (
  output logic link_clk,     // serial clock, 64 ns period
  output logic link_data,    // serial data
  output logic latch_strobe  // latch enable
);
  initial
  begin
    link_clk = 1'h0;
    link_data = 1'h0;
    latch_strobe = 1'h0;
  end

  // one word, top bit first; strobe kept long enough to cross over
  task automatic send(input logic [23:0] w);
    #5;
    for (int i = 23; i >= 0; i--)
    begin
      link_data = w[i];
      #32 link_clk = 1'h1;
      #32 link_clk = 1'h0;
    end
    link_data = ~link_data;
    #16 latch_strobe = 1'h1;
    #64 latch_strobe = 1'h0;
    #64;
  endtask : send
endmodule : pllfc_host_model
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: self-checking bench of the synthesizer control block
// Assumes: host model drives the link, bench drives the ref_clk pins
// Notes: expectations queued by the driver, compared by a watcher
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct {string nm; int k; logic [23:0] m, v;} pllfc_note_type;
  logic        ref_clk, rst, ce, pev, tick;
  logic [7:0]  src;
  logic        mon, pol, pt, hc, lfs, cl, crp, ldr, pd;
  logic        lclk, ldat, lstb;
  logic [23:0] dw, rw, w, d;
  logic [31:0] rnd = 32'h0000B99B;
  logic [7:0]  obs;
  int          bad_count, compares, p;
  int          pulses = 0;
  pllfc_note_type q[$];
  pllfc_note_type n;
  event        chk;
  assign obs = {mon, pol, pt, hc, lfs, cl, ldr, pd};

  pllfc_host_model i_host (.link_clk(lclk), .link_data(ldat),
    .latch_strobe(lstb));
  pllfc_core i_dut (.ref_clk(ref_clk), .rst(rst), .link_clk(lclk),
    .link_data(ldat), .latch_strobe(lstb), .chip_enable(ce),
    .pump_event(pev), .compare_tick(tick), .monitor_sources(src),
    .monitor_output_pin(mon), .phase_polarity_out(pol),
    .pump_tristate(pt), .pump_high_current(hc),
    .loop_filter_switch_out(lfs), .counter_load(cl),
    .counter_reset_pulse(crp), .lock_detect_reset(ldr),
    .powered_down(pd), .ref_word(rw), .div_word(dw));

  initial
  begin
    ref_clk = 1'h0;
    forever #4 ref_clk = ~ref_clk;
  end

  // the alignment pulse lasts one cycle, so it is counted here
  always @(posedge ref_clk)
    if (crp === 1'h1)
      pulses <= pulses + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // function word: timeout, fastlock, tristate, polarity, monitor, pd
  function automatic logic [23:0] fw(input logic [3:0] t, input logic f,
    input logic z, input logic o, input logic [2:0] s, input logic a,
    input logic c, input logic y);
    fw = {4'h0, y, 4'h0, t, 1'h0, f, z, o, s, a, c, 2'h2};
  endfunction : fw

  // expected outputs; switch low while boosted, follows variant when off
  function automatic logic [23:0] eo(input logic [23:0] x,
    input logic dn, input logic h);
    eo = {16'h0, src[x[6:4]], x[7], x[8] | x[2] | dn, h,
      (x[9] ? ~h : x[11]), x[2] | dn, dn, dn};
  endfunction : eo

  task automatic check(input string nm, input logic [23:0] seen,
    input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic note(input string nm, input int k, input logic [23:0] m,
    input logic [23:0] v);
    q.push_back('{nm, k, m, v});
    ->chk;
    cyc(1);
  endtask : note

  // watcher: kind 0 outputs, 1 pulse count, 2 divider word, 3 reference
  initial
    forever
    begin
      @(chk);
      while (q.size() > 0)
      begin
        n = q.pop_front();
        check(n.nm, (n.k == 0 ? {16'h0, obs} : n.k == 1 ? pulses[23:0] :
          n.k == 2 ? dw : rw) & n.m, n.v & n.m);
      end
    end

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : cyc

  // write a word and let it cross and settle
  task automatic wr(input logic [23:0] x);
    i_host.send(x);
    cyc(12);
  endtask : wr

  task automatic dv(input logic g);
    rnd = lfsr(rnd);
    d = {2'h0, g, rnd[18:0], 2'h1};
    wr(d);
  endtask : dv

  task automatic tk(input int c, input logic e);
    repeat (c)
    begin
      pev = e;
      tick = ~e;
      cyc(1);
      pev = 1'h0;
      tick = 1'h0;
      cyc(2);
    end
  endtask : tk

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // about 30 words of 2 us each; allow several times that
  initial
  begin
    #400000;
    bad_count++;
    end_of_test;
  end

  initial
  begin
    rst = 1'h1;
    ce = 1'h1;
    pev = 1'h0;
    tick = 1'h0;
    src = 8'h00;
    cyc(2);
    rst = 1'h0;
    cyc(8);
    for (int s = 0; s < 8; s++)
    begin
      rnd = lfsr(rnd);
      src = rnd[7:0];
      w = fw({3'h0, s[1]}, 1'h0, 1'h0, s[0], s[2:0], 1'h0, 1'h0, 1'h0);
      wr(w);
      note("mon", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    end
    $display("end monitor");
    w = fw(4'h0, 1'h0, 1'h1, 1'h0, 3'h2, 1'h0, 1'h0, 1'h0);
    wr(w);
    note("tri", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    w = fw(4'h0, 1'h0, 1'h0, 1'h1, 3'h3, 1'h0, 1'h1, 1'h0);
    wr(w);
    tk(2, 1'h1);
    note("clr", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    wr({rnd[21:0], 2'h0});
    note("rw", 3, 24'hFFFFFF, {rnd[21:0], 2'h0});
    dv(1'h0);
    w[2] = 1'h0;
    wr(w);
    note("clr0", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    note("nopulse", 1, 24'hFFFFFF, 24'h0);
    $display("end clear");
    ce = 1'h0;
    cyc(8);
    note("ce", 0, 24'hFF, eo(w, 1'h1, 1'h0));
    wr(w);
    wr({rnd[21:0], 2'h0});
    dv(1'h0);
    note("ce_wr", 0, 24'hFF, eo(w, 1'h1, 1'h0));
    note("ce_dw", 2, 24'hFFFFFF, d);
    ce = 1'h1;
    cyc(12);
    note("ce_up", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    w = fw(4'h0, 1'h0, 1'h0, 1'h0, 3'h1, 1'h1, 1'h0, 1'h0);
    wr(w);
    note("apd", 0, 24'hFF, eo(w, 1'h1, 1'h0));
    // disarm first: a held async power-down is not undone by a sync arm
    w[19] = 1'h1;
    w[3] = 1'h0;
    wr(w);
    w[3] = 1'h1;
    wr(w);
    note("spd0", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    tk(1, 1'h1);
    note("spd1", 0, 24'hFF, eo(w, 1'h1, 1'h0));
    $display("end power");
    w = fw(4'h0, 1'h1, 1'h0, 1'h0, 3'h4, 1'h0, 1'h0, 1'h0);
    wr(w);
    dv(1'h1);
    note("fl1", 0, 24'hFF, eo(w, 1'h0, 1'h1));
    note("dw", 2, 24'hFFFFFF, d);
    tk(20, 1'h0);
    note("fl1_hold", 0, 24'hFF, eo(w, 1'h0, 1'h1));
    dv(1'h0);
    note("fl1_end", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    w = fw(4'h3, 1'h1, 1'h0, 1'h0, 3'h4, 1'h0, 1'h0, 1'h0);
    wr(w);
    dv(1'h1);
    tk(3, 1'h0);
    note("fl2", 0, 24'hFF, eo(w, 1'h0, 1'h1));
    tk(1, 1'h0);
    note("fl2_end", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    note("gain", 2, 24'h200000, 24'h0);
    w = fw(4'h0, 1'h0, 1'h0, 1'h0, 3'h4, 1'h0, 1'h0, 1'h0);
    wr(w);
    dv(1'h1);
    note("fl_off", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    $display("end fastlock");
    p = pulses;
    w = fw(4'h0, 1'h0, 1'h0, 1'h1, 3'h5, 1'h0, 1'h0, 1'h0) | 24'h3;
    wr(w);
    note("init", 0, 24'hFF, eo(w, 1'h0, 1'h0));
    note("ipulse", 1, 24'hFFFFFF, 24'(p + 1));
    wr({rnd[21:0], 2'h0});
    dv(1'h0);
    note("dpulse", 1, 24'hFFFFFF, 24'(p + 2));
    dv(1'h0);
    note("dpulse2", 1, 24'hFFFFFF, 24'(p + 2));
    w = fw(4'h0, 1'h0, 1'h0, 1'h0, 3'h0, 1'h1, 1'h0, 1'h1) | 24'h3;
    wr(w);
    note("ipd", 0, 24'hFF, eo(w, 1'h1, 1'h0));
    $display("end init");
    end_of_test;
  end
endmodule : tb
`default_nettype wire
